// file: core/amc_pkg.sv
package amc_pkg;
    // Width of the channel selector field.
    localparam int AMC_SEL_W = 5;
    // Number of selector codes that name a real source.
    localparam int AMC_NUM_SRC = 24;
    // Selector codes that bound each group of sources.
    localparam logic [4:0] AMC_SEL_HIZ = 5'h00;
    localparam logic [4:0] AMC_SEL_MAIN_IN = 5'h01;
    localparam logic [4:0] AMC_SEL_BACKUP = 5'h02;
    localparam logic [4:0] AMC_SEL_COIN = 5'h03;
    localparam logic [4:0] AMC_SEL_BUCK_FIRST = 5'h04;
    localparam logic [4:0] AMC_SEL_BUCK_LAST = 5'h09;
    localparam logic [4:0] AMC_SEL_BUCK7 = 5'h0A;
    localparam logic [4:0] AMC_SEL_LINREG_FIRST = 5'h0B;
    localparam logic [4:0] AMC_SEL_LINREG_LAST = 5'h0E;
    localparam logic [4:0] AMC_SEL_DIE_TEMP = 5'h0F;
    localparam logic [4:0] AMC_SEL_TEMP_FIRST = 5'h10;
    localparam logic [4:0] AMC_SEL_TEMP_LAST = 5'h18;
    // Divide ratio codes, in hundredths, as reported beside the channel.
    localparam logic [9:0] AMC_RATIO_NONE = 10'h000;
    localparam logic [9:0] AMC_RATIO_1P00 = 10'h064;
    localparam logic [9:0] AMC_RATIO_1P25 = 10'h07D;
    localparam logic [9:0] AMC_RATIO_2P86 = 10'h11E;
    localparam logic [9:0] AMC_RATIO_3P00 = 10'h12C;
    localparam logic [9:0] AMC_RATIO_3P33 = 10'h14D;
    localparam logic [9:0] AMC_RATIO_3P50 = 10'h15E;
    localparam logic [9:0] AMC_RATIO_4P00 = 10'h190;
    // Pin state encodings: pulled to ground, floating or driven by the buffer.
    typedef enum logic [2:0] {
        AMC_PIN_GROUND = 3'b001,
        AMC_PIN_HIZ = 3'b010,
        AMC_PIN_DRIVE = 3'b100
    } amc_pin_t;
endpackage

// file: core/amc_channel_select.sv
`timescale 1ns/1ps
// How it works
// - enable low: mux off, pin grounded.
// - enable high: selector picks routed source.
// - enabled in system-on, code zero: pin high impedance.
// - codes 1-3: input, backup, coin cell.
// - codes 4-9: bucks one-six, ratio 1.25/1.
// - code 10 buck seven; 11-14 linear regulators.
// - codes 15-24 temperature sensors, undivided; rest reserved.
// - drive pin only in system-on states.
// - all ten temperature sensors reach the mux.
module amc_channel_select (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic monitor_enable_bit_i,
    input wire logic [amc_pkg::AMC_SEL_W-1:0] monitor_channel_selector_i,
    input wire logic system_on_i,
    input wire logic [5:0] buck_at_1v8_i,
    output logic [amc_pkg::AMC_NUM_SRC-1:0] source_switch_o,
    output logic buffer_on_o,
    output logic pulldown_on_o,
    output logic [9:0] divide_ratio_o
);
    import amc_pkg::*;

    // Whole block state: the switch vector, the pin condition and the divide ratio.
    typedef struct packed {
        logic [AMC_NUM_SRC-1:0] sw;
        amc_pin_t pin;
        logic [9:0] ratio;
    } amc_state_t;

    amc_state_t state_r;
    amc_state_t state_nxt;

    // Ratio for a given code; a buck's ratio depends on its voltage setting.
    // Codes outside every group give zero; the caller asks only for routed codes.
    function automatic logic [9:0] amc_ratio(input logic [4:0] sel, input logic [5:0] at18);
        logic [4:0] idx;
        idx = sel - AMC_SEL_BUCK_FIRST;
        if (sel == AMC_SEL_MAIN_IN) begin
            amc_ratio = AMC_RATIO_4P00;
        end else if (sel == AMC_SEL_BACKUP) begin
            amc_ratio = AMC_RATIO_3P50;
        end else if (sel == AMC_SEL_COIN) begin
            amc_ratio = AMC_RATIO_3P00;
        end else if (sel >= AMC_SEL_BUCK_FIRST && sel <= AMC_SEL_BUCK_LAST) begin
            amc_ratio = at18[idx[2:0]] ? AMC_RATIO_1P25 : AMC_RATIO_1P00;
        end else if (sel == AMC_SEL_BUCK7) begin
            amc_ratio = AMC_RATIO_2P86;
        end else if (sel >= AMC_SEL_LINREG_FIRST && sel <= AMC_SEL_LINREG_LAST) begin
            amc_ratio = AMC_RATIO_3P33;
        end else if (sel >= AMC_SEL_DIE_TEMP && sel <= AMC_SEL_TEMP_LAST) begin
            amc_ratio = AMC_RATIO_1P00;
        end else begin
            amc_ratio = AMC_RATIO_NONE;
        end
    endfunction

    // A code names a source only between one and the last sensor code.
    function automatic logic amc_is_source(input logic [4:0] sel);
        amc_is_source = (sel != AMC_SEL_HIZ) && (sel <= AMC_SEL_TEMP_LAST);
    endfunction

    // Next state. Outside system-on the pin is grounded, the safe idle level.
    always_comb begin
        state_nxt = state_r;
        if (clk_en_i) begin
            state_nxt.sw = '0;
            state_nxt.ratio = AMC_RATIO_NONE;
            if (!monitor_enable_bit_i || !system_on_i) begin
                state_nxt.pin = AMC_PIN_GROUND;
            end else if (!amc_is_source(monitor_channel_selector_i)) begin
                // Reserved codes float the pin just like code zero.
                state_nxt.pin = AMC_PIN_HIZ;
            end else begin
                // One-hot switch; code n closes bit n-1.
                state_nxt.pin = AMC_PIN_DRIVE;
                state_nxt.sw[monitor_channel_selector_i - 5'h01] = 1'h1;
                state_nxt.ratio = amc_ratio(monitor_channel_selector_i, buck_at_1v8_i);
            end
        end
    end

    // Registering the choice keeps switch changes glitch free.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= '{sw: '0, pin: AMC_PIN_GROUND, ratio: AMC_RATIO_NONE};
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs decode straight from registered state, so the analog switches never glitch.
    assign source_switch_o = state_r.sw;
    assign buffer_on_o = (state_r.pin == AMC_PIN_DRIVE);
    assign pulldown_on_o = (state_r.pin == AMC_PIN_GROUND);
    assign divide_ratio_o = state_r.ratio;

    // Disabled monitor grounds the pin one cycle later.
    chk_disabled_grounds: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && !monitor_enable_bit_i) |=> (pulldown_on_o && source_switch_o == '0))
        else $error("pin not grounded while disabled");
    // Code zero floats the pin.
    chk_zero_floats: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h00)
        |=> (!pulldown_on_o && !buffer_on_o))
        else $error("code zero did not float pin");
    // Reserved codes float the pin with no switch closed.
    chk_reserved_floats: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i > 5'h18)
        |=> (!buffer_on_o && source_switch_o == '0))
        else $error("reserved code drove pin");
    // A valid code closes exactly the matching switch.
    chk_route_onehot: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i != 5'h00
        && monitor_channel_selector_i <= 5'h18)
        |=> (buffer_on_o
        && source_switch_o == (24'h000001 << ($past(monitor_channel_selector_i) - 5'h01))))
        else $error("wrong switch closed");
    // Input supply reports ratio four.
    chk_main_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h01)
        |=> divide_ratio_o == 10'h190)
        else $error("main input ratio wrong");
    // Buck one at 1.8 V reports 1.25.
    chk_buck_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h04
        && buck_at_1v8_i[0]) |=> divide_ratio_o == 10'h07D)
        else $error("buck ratio wrong");
    // Linear regulators report 3.33.
    chk_linreg_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h0C)
        |=> divide_ratio_o == 10'h14D)
        else $error("linear regulator ratio wrong");
    // Sensors are undivided.
    chk_sensor_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h18)
        |=> divide_ratio_o == 10'h064)
        else $error("sensor ratio wrong");
    // Outside system-on the buffer never drives.
    chk_sysoff_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && !system_on_i) |=> !buffer_on_o)
        else $error("buffer on outside system-on");

    // The checks below pin down each source group by its first or last code, or both.

    // Input supply closes the first switch.
    chk_main_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h01)
        |=> (buffer_on_o && source_switch_o == 24'h000001))
        else $error("main input route wrong");

    // Backup rail closes the second switch and reports 3.5.
    chk_backup_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h02)
        |=> (source_switch_o == 24'h000002 && divide_ratio_o == AMC_RATIO_3P50))
        else $error("backup rail route wrong");

    // Coin cell closes the third switch and reports 3.
    chk_coin_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h03)
        |=> (source_switch_o == 24'h000004 && divide_ratio_o == AMC_RATIO_3P00))
        else $error("coin cell route wrong");

    // Buck six at any other setting is undivided.
    chk_buck_plain_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h09
        && !buck_at_1v8_i[5]) |=> divide_ratio_o == AMC_RATIO_1P00)
        else $error("buck plain ratio wrong");

    // Buck six at 1.8 V reports 1.25, so the flag index must track the code.
    chk_buck_fast_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h09
        && buck_at_1v8_i[5]) |=> divide_ratio_o == AMC_RATIO_1P25)
        else $error("buck six ratio wrong");

    // Buck seven has its own fixed divider.
    chk_buck7_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h0A)
        |=> (source_switch_o == 24'h000200 && divide_ratio_o == AMC_RATIO_2P86))
        else $error("buck seven route wrong");

    // First linear regulator follows straight after buck seven.
    chk_linreg_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h0B)
        |=> (source_switch_o == 24'h000400 && divide_ratio_o == AMC_RATIO_3P33))
        else $error("linear regulator route wrong");

    // The die-centre sensor also feeds thermal shutdown; it reaches the pin undivided.
    chk_die_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h0F)
        |=> (source_switch_o == 24'h004000 && divide_ratio_o == AMC_RATIO_1P00))
        else $error("die sensor route wrong");

    // First sensor beside the bucks.
    chk_sensor_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h10)
        |=> (source_switch_o == 24'h008000 && divide_ratio_o == AMC_RATIO_1P00))
        else $error("buck sensor route wrong");

    // Last sensor takes the top switch.
    chk_last_sensor_route: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i && monitor_channel_selector_i == 5'h18)
        |=> (buffer_on_o && source_switch_o == 24'h800000))
        else $error("last sensor route wrong");

    // Floating codes report no divider and release the pulldown.
    chk_float_no_ratio: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && system_on_i
        && (monitor_channel_selector_i == 5'h00 || monitor_channel_selector_i > 5'h18))
        |=> (!pulldown_on_o && divide_ratio_o == AMC_RATIO_NONE))
        else $error("floating code reported a divider");

    // A disabled monitor reports no divider and keeps the buffer off.
    chk_disabled_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && !monitor_enable_bit_i)
        |=> (!buffer_on_o && divide_ratio_o == AMC_RATIO_NONE))
        else $error("disabled monitor still active");

    // Outside system-on the pin is grounded with every switch open.
    chk_sysoff_grounds: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && monitor_enable_bit_i && !system_on_i)
        |=> (pulldown_on_o && source_switch_o == '0 && divide_ratio_o == AMC_RATIO_NONE))
        else $error("pin not grounded outside system-on");

    // A low clock enable freezes the routing, so no switch moves behind the host's back.
    chk_freeze_holds: assert property (@(posedge clk_i) disable iff (reset_i)
        !clk_en_i |=> ($stable(source_switch_o) && $stable(divide_ratio_o)
        && $stable(buffer_on_o) && $stable(pulldown_on_o)))
        else $error("outputs moved with clock enable low");
endmodule

// file: tb/amc_adc_model.sv
`timescale 1ns/1ps
// Far-side converter: it only sees what state the monitor pin is left in.
module amc_adc_model (
    input wire logic buffer_on_i,
    input wire logic pulldown_on_i,
    output amc_pkg::amc_pin_t pin_o
);
    import amc_pkg::*;
    // Neither control on means the pin floats, and the converter reads nothing useful.
    always_comb begin
        pin_o = buffer_on_i ? AMC_PIN_DRIVE : (pulldown_on_i ? AMC_PIN_GROUND : AMC_PIN_HIZ);
    end
endmodule

// file: tb/tb_amc_channel_select.sv
`timescale 1ns/1ps
module tb_amc_channel_select;
    import amc_pkg::*;
    logic clk_i = 0, reset_i = 1, clk_en_i = 1, en = 0, son = 0;
    logic [4:0] sel = 5'h00;
    logic [5:0] b18 = 6'h00;
    logic [23:0] sw;
    logic buf_on, pd_on;
    logic [9:0] ratio;
    amc_pin_t pin;
    int mismatches = 0, num_checks = 0, cycles = 0;
    amc_channel_select dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .monitor_enable_bit_i(en), .monitor_channel_selector_i(sel), .system_on_i(son),
        .buck_at_1v8_i(b18), .source_switch_o(sw), .buffer_on_o(buf_on),
        .pulldown_on_o(pd_on), .divide_ratio_o(ratio));
    amc_adc_model adc (.buffer_on_i(buf_on), .pulldown_on_i(pd_on), .pin_o(pin));
    initial forever #12.5 clk_i = ~clk_i;
    // The whole run needs about 95 cycles, so 2000 only trips on a hang.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ratio in hundredths for a routed code, buck codes reading the 1.8 V flags.
    function automatic logic [9:0] exp_ratio(input logic [4:0] c);
        if (c == 5'h01) return 10'h190;
        if (c == 5'h02) return 10'h15E;
        if (c == 5'h03) return 10'h12C;
        if (c <= 5'h09) return b18[c - 5'h04] ? 10'h07D : 10'h064;
        if (c == 5'h0A) return 10'h11E;
        if (c <= 5'h0E) return 10'h14D;
        return 10'h064;
    endfunction
    // Inputs move 1 ns after an edge; results are read 1 ns after the next edge.
    task automatic apply(input logic e, input logic o, input logic [4:0] c);
        @(posedge clk_i);
        #1;
        en = e;
        son = o;
        sel = c;
        @(posedge clk_i);
        #1;
    endtask
    task automatic step(input logic e, input logic o, input logic [4:0] c);
        logic live;
        amc_pin_t want;
        apply(e, o, c);
        live = e && o && c >= 5'h01 && c <= 5'h18;
        want = live ? AMC_PIN_DRIVE : ((e && o) ? AMC_PIN_HIZ : AMC_PIN_GROUND);
        check("switch", sw, live ? 32'h1 << (c - 5'h01) : 32'h0);
        check("buffer", buf_on, live);
        check("pulldown", pd_on, !(e && o));
        check("ratio", ratio, live ? exp_ratio(c) : 10'h000);
        check("pin", pin, want);
    endtask
    // Every code back to back, then the buck flags inverted; host waits are not modelled.
    task automatic t_sweep();
        b18 = 6'h15;
        for (int c = 0; c < 25; c++) step(1, 1, c[4:0]);
        // Reserved codes break the host's side on purpose to show the pin floats undriven.
        for (int c = 25; c < 32; c++) step(1, 1, c[4:0]);
        b18 = 6'h2A;
        for (int c = 4; c < 10; c++) step(1, 1, c[4:0]);
    endtask
    task automatic t_off();
        step(0, 1, 5'h05);
        step(0, 1, 5'h1F);
        step(1, 0, 5'h01);
        step(0, 0, 5'h0A);
    endtask
    // With the clock enable low a new selection must not reach the outputs.
    task automatic t_freeze();
        step(1, 1, 5'h0F);
        clk_en_i = 0;
        apply(0, 1, 5'h02);
        check("held switch", sw, 32'h4000);
        check("held buffer", buf_on, 1'h1);
        check("held pulldown", pd_on, 1'h0);
        check("held ratio", ratio, 10'h064);
        clk_en_i = 1;
        step(1, 1, 5'h18);
    endtask
    task automatic t_reset();
        reset_i = 1;
        #1;
        check("reset pulldown", pd_on, 1'b1);
        check("reset switch", sw, 32'h0);
        check("reset buffer", buf_on, 1'h0);
        check("reset ratio", ratio, 10'h000);
        @(posedge clk_i);
        #1;
        reset_i = 0;
        step(1, 1, 5'h03);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 0;
        t_sweep();
        t_off();
        t_freeze();
        t_reset();
        wrap_up();
    end
endmodule
